// file: common/ptw_consts.svh
// Offsets, field positions, reset values and fixed answers of the target memory windows
`ifndef PTW_CONSTS_SVH
`define PTW_CONSTS_SVH

`define PTW_WIN0_LO_OFS 16'hd180
`define PTW_WIN0_HI_OFS 16'hd184
`define PTW_WIN1_LO_OFS 16'hd188
`define PTW_WIN1_HI_OFS 16'hd18c

`define PTW_EN_BIT 6
`define PTW_SWAP_BIT 5
`define PTW_XFER_BIT 4
`define PTW_BASE_HI_MSB 3
`define PTW_BASE_LO_LSB 24
`define PTW_BASE_FIELD_LSB 24
`define PTW_W0_BASE_LSB 29
`define PTW_W1_BASE_LSB 24

`define PTW_EN_RST 1'b0
`define PTW_SWAP_RST_LE 1'b1
`define PTW_SWAP_RST_BE 1'b0
`define PTW_XFER_RST_LE 1'b0
`define PTW_XFER_RST_BE 1'b1
`define PTW_BASE_RST 12'h000
`define PTW_W0_BASE_MASK 12'hfe0
`define PTW_W1_BASE_MASK 12'hfff

`define PTW_W0_OFF_READ 32'h0000_0000
`define PTW_W1_OFF_READ 32'h0000_0001
`define PTW_BAR_TYPE 4'h4

`define PTW_RSP_OKAY 2'h0
`define PTW_RSP_SLVERR 2'h2

`endif

// file: common/ptw_pkg.sv
// Types shared by the target memory window map and its window slice
package ptw_pkg;

  typedef struct packed {
    logic en;
    logic swapDis;
    logic xfer;
    logic [11:0] base;
  } ptw_wincfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic win;
    logic upper;
    logic [31:0] data;
  } ptw_cfgreq_t;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [31:0] data;
  } ptw_tgtreq_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic win;
    logic [35:0] gaddr;
    logic [31:0] data;
    logic swap;
    logic xfer;
  } ptw_tgtrsp_t;

endpackage : ptw_pkg

// file: rtl/ptw_win_xlate.sv
// One target memory window: configuration-space base address pair and address match
`timescale 1ns/1ps
`include "ptw_consts.svh"

module ptw_win_xlate import ptw_pkg::*; #(
  parameter int BASE_LSB = 29,
  parameter logic [31:0] OFF_READ = 32'h0000_0000
) (
  input wire logic clk,            // System clock
  input wire logic arst_n,         // Async reset, active low
  input wire ptw_wincfg_t winCfg,  // Window control from register file
  input wire logic cfgWr,          // Config write to this window
  input wire logic cfgUpper,       // Selects upper base register
  input wire logic [31:0] cfgWdata, // Config write data
  output logic [31:0] cfgRdata,    // Config read value
  input wire logic [63:0] tgtAddr, // PCI target address
  output logic hit,                // Address falls in window
  output logic [35:0] gaddr        // Internal bus address
);

  logic [31:BASE_LSB] barLo_reg;
  logic [31:0] barHi_reg;
  logic [31:0] barLoView;
  logic wrLo;
  logic wrHi;

  // RULE1: writes dropped while window off
  assign wrLo = cfgWr && winCfg.en && !cfgUpper;
  assign wrHi = cfgWr && winCfg.en && cfgUpper;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      barLo_reg <= '0;
      barHi_reg <= 32'h0000_0000;
    end else begin
      if (wrLo) begin
        barLo_reg <= cfgWdata[31:BASE_LSB];
      end
      if (wrHi) begin
        barHi_reg <= cfgWdata;
      end
    end
  end

  assign barLoView = {barLo_reg, {(BASE_LSB - 4){1'b0}}, `PTW_BAR_TYPE};

  // RULE2: disabled window answers fixed value
  assign cfgRdata = !winCfg.en ? OFF_READ : (cfgUpper ? barHi_reg : barLoView);

  // RULE10: base bits over offset bits
  assign hit = winCfg.en && (tgtAddr[63:BASE_LSB] == {barHi_reg, barLo_reg});
  assign gaddr = {winCfg.base[11:BASE_LSB - `PTW_BASE_FIELD_LSB], tgtAddr[BASE_LSB - 1:0]};

endmodule : ptw_win_xlate

// file: rtl/ptw_memwin_map.sv
// Target memory window map: Avalon-MM register file, config base registers, address translation
`timescale 1ns/1ps
`include "ptw_consts.svh"

// Contract
// RULE1: window0_enable bit 38 gates window 0
// RULE2: window1_enable bit 38 gates window 1
// RULE3: bit 37 window 0 swap_disable, mode reset
// RULE4: bit 37 window 1 swap_disable, mode reset
// RULE5: big endian, swap_disable set keeps order
// RULE6: bit 36 window 0 endian_xfer, mode reset
// RULE7: bit 36 window 1 endian_xfer, mode reset
// RULE8: window 0 base 35:29, 512 MB
// RULE9: window 1 base 35:24, 16 MB
// RULE10: internal address is base plus offset
module ptw_memwin_map import ptw_pkg::*; (
  input wire logic clk,                  // 100 MHz system clock
  input wire logic arst_n,               // Async reset, active low
  input wire logic bigEndianMode,        // Endian mode strap, high for big
  input wire logic [15:0] avsAddress,    // Avalon byte address
  input wire logic avsRead,              // Avalon read request
  input wire logic avsWrite,             // Avalon write request
  input wire logic [31:0] avsWritedata,  // Avalon write data
  input wire logic [3:0] avsByteenable,  // Avalon byte lanes
  output logic [31:0] avsReaddata,       // Avalon read data
  output logic avsWaitrequest,           // Avalon wait, low marks answer
  output logic [1:0] avsResponse,        // Avalon response code
  input wire ptw_cfgreq_t cfgReq,        // Config-space base register access
  output logic [31:0] cfgRdata,          // Config read data
  output logic cfgRvalid,                // Config read data valid pulse
  input wire ptw_tgtreq_t tgtReq,        // PCI target access
  output ptw_tgtrsp_t tgtRsp,            // Translated target access
  output ptw_wincfg_t win0State,         // Window 0 controls
  output ptw_wincfg_t win1State          // Window 1 controls
);

  // Merge one bus write into a window's controls
  function automatic ptw_wincfg_t applyWrite(
    input ptw_wincfg_t cur,
    input logic wrHi,
    input logic wrLo,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [11:0] mask
  );
    ptw_wincfg_t res;
    res = cur;
    if (wrHi && be[0]) begin
      res.en = wdata[`PTW_EN_BIT];
      res.swapDis = wdata[`PTW_SWAP_BIT];
      res.xfer = wdata[`PTW_XFER_BIT];
      res.base[11:8] = wdata[`PTW_BASE_HI_MSB:0];
    end
    if (wrLo && be[3]) begin
      res.base[7:0] = wdata[31:`PTW_BASE_LO_LSB];
    end
    res.base = res.base & mask;
    return res;
  endfunction : applyWrite

  // Present one word of a window register
  function automatic logic [31:0] readWord(input ptw_wincfg_t cfg, input logic upper);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (upper) begin
      w[`PTW_EN_BIT] = cfg.en;
      w[`PTW_SWAP_BIT] = cfg.swapDis;
      w[`PTW_XFER_BIT] = cfg.xfer;
      w[`PTW_BASE_HI_MSB:0] = cfg.base[11:8];
    end else begin
      w[31:`PTW_BASE_LO_LSB] = cfg.base[7:0];
    end
    return w;
  endfunction : readWord

  // Swap the four bytes of a word
  function automatic logic [31:0] swapBytes(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swapBytes

  ptw_wincfg_t win0_reg;
  ptw_wincfg_t win0_next;
  ptw_wincfg_t win1_reg;
  ptw_wincfg_t win1_next;
  logic strapDone_reg;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic [31:0] cfgRdata_reg;
  logic cfgRvalid_reg;
  ptw_tgtrsp_t tgtRsp_reg;
  ptw_tgtrsp_t tgtRsp_next;

  // Bus decode
  wire logic selW0Lo = (avsAddress == `PTW_WIN0_LO_OFS);
  wire logic selW0Hi = (avsAddress == `PTW_WIN0_HI_OFS);
  wire logic selW1Lo = (avsAddress == `PTW_WIN1_LO_OFS);
  wire logic selW1Hi = (avsAddress == `PTW_WIN1_HI_OFS);
  wire logic selAny = selW0Lo | selW0Hi | selW1Lo | selW1Hi;
  wire logic busReq = avsRead | avsWrite;
  wire logic busTake = busReq && wait_reg && strapDone_reg;
  wire logic wrFire = avsWrite && !wait_reg;
  wire logic [31:0] busRdMux = selW0Lo ? readWord(win0_reg, 1'b0) :
                               selW0Hi ? readWord(win0_reg, 1'b1) :
                               selW1Lo ? readWord(win1_reg, 1'b0) :
                               selW1Hi ? readWord(win1_reg, 1'b1) : 32'h0000_0000;

  // Mode-dependent defaults for swap and endian transfer
  wire logic swapDflt = bigEndianMode ? `PTW_SWAP_RST_BE : `PTW_SWAP_RST_LE;
  wire logic xferDflt = bigEndianMode ? `PTW_XFER_RST_BE : `PTW_XFER_RST_LE;

  // Config access routing
  wire logic cfgWr0 = cfgReq.wr && !cfgReq.win;
  wire logic cfgWr1 = cfgReq.wr && cfgReq.win;
  logic [31:0] cfgRd0;
  logic [31:0] cfgRd1;
  logic hit0;
  logic hit1;
  logic [35:0] gaddr0;
  logic [35:0] gaddr1;

  ptw_win_xlate #(
    .BASE_LSB(`PTW_W0_BASE_LSB),
    .OFF_READ(`PTW_W0_OFF_READ)
  ) uWin0 (
    .clk(clk),
    .arst_n(arst_n),
    .winCfg(win0_reg),
    .cfgWr(cfgWr0),
    .cfgUpper(cfgReq.upper),
    .cfgWdata(cfgReq.data),
    .cfgRdata(cfgRd0),
    .tgtAddr(tgtReq.addr),
    .hit(hit0),
    .gaddr(gaddr0)
  );

  ptw_win_xlate #(
    .BASE_LSB(`PTW_W1_BASE_LSB),
    .OFF_READ(`PTW_W1_OFF_READ)
  ) uWin1 (
    .clk(clk),
    .arst_n(arst_n),
    .winCfg(win1_reg),
    .cfgWr(cfgWr1),
    .cfgUpper(cfgReq.upper),
    .cfgWdata(cfgReq.data),
    .cfgRdata(cfgRd1),
    .tgtAddr(tgtReq.addr),
    .hit(hit1),
    .gaddr(gaddr1)
  );

  // Window register next values
  always_comb begin
    win0_next = win0_reg;
    win1_next = win1_reg;
    if (!strapDone_reg) begin
      // RULE3: window 0 swap default
      win0_next.swapDis = swapDflt;
      // RULE6: window 0 transfer default
      win0_next.xfer = xferDflt;
      // RULE4: window 1 swap default
      win1_next.swapDis = swapDflt;
      // RULE7: window 1 transfer default
      win1_next.xfer = xferDflt;
    end else begin
      // RULE8: window 0 base field
      win0_next = applyWrite(win0_reg, wrFire && selW0Hi, wrFire && selW0Lo,
                             avsWritedata, avsByteenable, `PTW_W0_BASE_MASK);
      // RULE9: window 1 base field
      win1_next = applyWrite(win1_reg, wrFire && selW1Hi, wrFire && selW1Lo,
                             avsWritedata, avsByteenable, `PTW_W1_BASE_MASK);
    end
  end

  // One wait state per access, held off until the strap is caught
  always_comb begin
    wait_next = 1'b1;
    if (busTake) begin
      wait_next = 1'b0;
    end
  end

  // Target access translation
  wire logic tgtHit = hit0 | hit1;
  wire logic tgtWin = !hit0 && hit1;
  wire logic selSwapDis = tgtWin ? win1_reg.swapDis : win0_reg.swapDis;
  wire logic selXfer = tgtWin ? win1_reg.xfer : win0_reg.xfer;

  always_comb begin
    tgtRsp_next = '0;
    tgtRsp_next.valid = tgtReq.valid;
    tgtRsp_next.hit = tgtReq.valid && tgtHit;
    tgtRsp_next.win = tgtWin;
    // RULE10: translated internal address
    tgtRsp_next.gaddr = tgtWin ? gaddr1 : gaddr0;
    tgtRsp_next.swap = tgtHit && !selSwapDis;
    tgtRsp_next.xfer = tgtHit && selXfer;
    // RULE5: no swap keeps byte order
    tgtRsp_next.data = (tgtHit && !selSwapDis) ? swapBytes(tgtReq.data) : tgtReq.data;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // RULE1: window 0 off at reset
      win0_reg <= '{en: `PTW_EN_RST, swapDis: `PTW_SWAP_RST_LE, xfer: `PTW_XFER_RST_LE,
                    base: `PTW_BASE_RST};
      // RULE2: window 1 off at reset
      win1_reg <= '{en: `PTW_EN_RST, swapDis: `PTW_SWAP_RST_LE, xfer: `PTW_XFER_RST_LE,
                    base: `PTW_BASE_RST};
      strapDone_reg <= 1'b0;
    end else begin
      win0_reg <= win0_next;
      win1_reg <= win1_next;
      strapDone_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= `PTW_RSP_OKAY;
    end else begin
      wait_reg <= wait_next;
      if (busTake) begin
        rdata_reg <= avsRead ? busRdMux : 32'h0000_0000;
        resp_reg <= selAny ? `PTW_RSP_OKAY : `PTW_RSP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgRdata_reg <= 32'h0000_0000;
      cfgRvalid_reg <= 1'b0;
      tgtRsp_reg <= '0;
    end else begin
      cfgRvalid_reg <= cfgReq.rd;
      if (cfgReq.rd) begin
        cfgRdata_reg <= cfgReq.win ? cfgRd1 : cfgRd0;
      end
      tgtRsp_reg <= tgtRsp_next;
    end
  end

  assign avsReaddata = rdata_reg;
  assign avsWaitrequest = wait_reg;
  assign avsResponse = resp_reg;
  assign cfgRdata = cfgRdata_reg;
  assign cfgRvalid = cfgRvalid_reg;
  assign tgtRsp = tgtRsp_reg;
  assign win0State = win0_reg;
  assign win1State = win1_reg;

endmodule : ptw_memwin_map

// file: verif/ptw_map_props.sv
// Concurrent checks on the target memory window map ports
`timescale 1ns/1ps
module ptw_map_props import ptw_pkg::*; (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic avsWaitrequest, // Bus wait
  input wire ptw_tgtreq_t tgtReq, // Target access
  input wire ptw_tgtrsp_t tgtRsp, // Translated access
  input wire ptw_wincfg_t win0State, // Window 0 controls
  input wire ptw_wincfg_t win1State // Window 1 controls
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic hit0 = tgtRsp.hit && !tgtRsp.win;
  wire logic hit1 = tgtRsp.hit && tgtRsp.win;
  a_hit0_enabled: assert property (hit0 |-> $past(win0State.en))
    else $error("window 0 hit while disabled");
  a_hit1_enabled: assert property (hit1 |-> $past(win1State.en))
    else $error("window 1 hit while disabled");
  a_swap_win0: assert property (hit0 |-> tgtRsp.swap == !$past(win0State.swapDis))
    else $error("window 0 swap flag wrong");
  a_swap_win1: assert property (hit1 |-> tgtRsp.swap == !$past(win1State.swapDis))
    else $error("window 1 swap flag wrong");
  a_keep_order: assert property (tgtRsp.hit && !tgtRsp.swap |-> tgtRsp.data == $past(tgtReq.data))
    else $error("unswapped data changed");
  a_xfer_flag: assert property (tgtRsp.hit |-> tgtRsp.xfer ==
    (tgtRsp.win ? $past(win1State.xfer) : $past(win0State.xfer)))
    else $error("endian transfer flag wrong");
  a_base0_coarse: assert property (win0State.base[4:0] == 5'h00)
    else $error("window 0 base keeps fine bits");
  a_gaddr_win0: assert property (hit0 |->
    tgtRsp.gaddr == {$past(win0State.base[11:5]), $past(tgtReq.addr[28:0])})
    else $error("window 0 address wrong");
  a_gaddr_win1: assert property (hit1 |->
    tgtRsp.gaddr == {$past(win1State.base), $past(tgtReq.addr[23:0])})
    else $error("window 1 address wrong");
  a_wait_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("wait low longer than one cycle");
  c_hit0: cover property (hit0);
  c_hit1: cover property (hit1);
  c_answer: cover property (!avsWaitrequest);
endmodule : ptw_map_props

// file: verif/ptw_pci_master.sv
// Behavioural PCI master issuing single target accesses
`timescale 1ns/1ps
module ptw_pci_master import ptw_pkg::*; (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic issue, // Start one access
  input wire logic [63:0] reqAddr, // Access address
  input wire logic [31:0] reqData, // Access data
  output ptw_tgtreq_t tgtReq // Request to bridge
);
  // Idle lines show inverted junk, not the last value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgtReq <= '0;
    end else if (issue) begin
      tgtReq <= {1'b1, reqAddr, reqData};
    end else begin
      tgtReq <= {1'b0, ~tgtReq.addr, ~tgtReq.data};
    end
  end
endmodule : ptw_pci_master

// file: verif/tb_ptw_memwin_map.sv
// Self-checking bench for the target memory window map
`timescale 1ns/1ps
module tb_ptw_memwin_map import ptw_pkg::*; ();
  logic clk, arst_n, bigEndianMode, avsRead, avsWrite, avsWaitrequest, cfgRvalid, issue;
  logic [15:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, cfgRdata, reqData, q;
  logic [1:0] avsResponse, rsp;
  logic [63:0] reqAddr;
  ptw_cfgreq_t cfgReq;
  ptw_tgtreq_t tgtReq;
  ptw_tgtrsp_t tgtRsp;
  ptw_wincfg_t win0State, win1State;
  int fails, cmp_count;
  ptw_memwin_map i_dut (.clk, .arst_n, .bigEndianMode, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .avsResponse,
    .cfgReq, .cfgRdata, .cfgRvalid, .tgtReq, .tgtRsp, .win0State, .win1State);
  ptw_pci_master i_pci (.clk, .arst_n, .issue, .reqAddr, .reqData, .tgtReq);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsWrite <= wr;
    avsRead <= !wr;
    avsAddress <= a;
    avsWritedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    q = avsReaddata;
    rsp = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 20) begin
      fails++;
      summarize();
    end
  endtask : bus
  // Fields: read, write, window, upper
  task automatic cfg(input logic [3:0] k, input logic [31:0] d);
    @(posedge clk);
    cfgReq <= {k, d};
    @(posedge clk);
    cfgReq <= '0;
    #1 q = cfgRdata;
    chk(cfgRvalid, k[3]);
  endtask : cfg
  task automatic tgt(input logic [63:0] a, input logic [31:0] d);
    @(posedge clk);
    issue <= 1'b1;
    reqAddr <= a;
    reqData <= d;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
    #1;
  endtask : tgt
  task automatic t_reset(input logic be);
    @(posedge clk);
    arst_n <= 1'b0;
    bigEndianMode <= be;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, 16'hd184, '0);
    chk(q, be ? 32'h10 : 32'h20);
    bus(1'b0, 16'hd18c, '0);
    chk(q, be ? 32'h10 : 32'h20);
    bus(1'b0, 16'hd180, '0);
    chk(q, 32'h0);
    bus(1'b0, 16'hd188, '0);
    chk(q, 32'h0);
    chk({win0State, win1State}, be ? 30'h0800_1000 : 30'h1000_2000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_gate();
    cfg(4'b0101, 32'h1234_5678);
    cfg(4'b1001, '0);
    chk(q, 32'h0);
    cfg(4'b0111, 32'h1234_5678);
    cfg(4'b1011, '0);
    chk(q, 32'h1);
    cfg(4'b1010, '0);
    chk(q, 32'h1);
    $display("gate test done");
  endtask : t_gate
  task automatic t_win0();
    bus(1'b1, 16'hd184, 32'h45);
    bus(1'b1, 16'hd180, 32'hffff_ffff);
    bus(1'b0, 16'hd180, '0);
    chk(q, 32'he000_0000);
    cfg(4'b1001, '0);
    chk(q, 32'h0);
    cfg(4'b0101, 32'h1);
    cfg(4'b0100, 32'h6000_0000);
    cfg(4'b1000, '0);
    chk(q, 32'h6000_0004);
    tgt(64'h1_7234_5678, 32'h1122_3344);
    chk(tgtRsp.hit, 1'b1);
    chk(tgtRsp.gaddr, 36'h5_f234_5678);
    chk(tgtRsp.data, 32'h4433_2211);
    chk({tgtRsp.valid, tgtRsp.swap}, 2'b11);
    bus(1'b1, 16'hd184, 32'h65);
    tgt(64'h1_7234_5678, 32'h1122_3344);
    chk(tgtRsp.data, 32'h1122_3344);
    $display("window 0 test done");
  endtask : t_win0
  task automatic t_win1();
    bus(1'b1, 16'hd18c, 32'h53);
    bus(1'b1, 16'hd188, 32'hab00_0000);
    cfg(4'b1011, '0);
    chk(q, 32'h0);
    cfg(4'b0110, 32'h0500_0000);
    cfg(4'b1010, '0);
    chk(q, 32'h0500_0004);
    tgt(64'h05ab_cdef, 32'h0);
    chk({tgtRsp.hit, tgtRsp.win, tgtRsp.xfer}, 3'b111);
    chk(tgtRsp.gaddr, 36'h3_abab_cdef);
    bus(1'b1, 16'hd184, 32'h0);
    tgt(64'h1_7234_5678, 32'h0);
    chk(tgtRsp.hit, 1'b0);
    bus(1'b1, 16'hd190, 32'hffff_ffff);
    bus(1'b0, 16'hd190, '0);
    chk({rsp, q}, {2'h2, 32'h0});
    $display("window 1 test done");
  endtask : t_win1
  initial begin
    arst_n = 1'b0;
    bigEndianMode = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = '0;
    avsWritedata = '0;
    cfgReq = '0;
    issue = 1'b0;
    reqAddr = '0;
    reqData = '0;
    fails = 0;
    cmp_count = 0;
    t_reset(1'b0);
    t_gate();
    t_win0();
    t_win1();
    t_reset(1'b1);
    t_win0();
    summarize();
  end
endmodule : tb_ptw_memwin_map

bind ptw_memwin_map ptw_map_props i_props (.clk, .arst_n, .avsWaitrequest, .tgtReq, .tgtRsp,
  .win0State, .win1State);
